// [design/pmrc_consts.svh]
/*
  Constants for the power monitor and reset control block: register
  offsets, field positions, reset values and timing counts.
  Assumes inclusion by its bare name from the package and the design.
*/
`ifndef PMRC_CONSTS_SVH
`define PMRC_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PMRC_OFS_RESET_SOURCE_REG   8'h00
`define PMRC_OFS_UCFG     8'h04
`define PMRC_OFS_DETCFG   8'h08
`define PMRC_OFS_PWRCTL   8'h0C
`define PMRC_OFS_STATUS   8'h10
`define PMRC_OFS_BOOTVEC  8'h14

// ****************************************************************
// Reset source flag positions
// ****************************************************************
`define PMRC_RS_PIN   0
`define PMRC_RS_SW    1
`define PMRC_RS_WDT   2
`define PMRC_RS_DROP  3
`define PMRC_RS_BRK   4
`define PMRC_RS_PON   5
`define PMRC_RS_W     6

// ****************************************************************
// User config fields
// ****************************************************************
`define PMRC_UC_LVL_LO  3
`define PMRC_UC_LVL_HI  5
`define PMRC_UC_RPE     6

// ****************************************************************
// Detector config fields
// ****************************************************************
`define PMRC_DC_IRQ_EN  0
`define PMRC_DC_LVL_LO  1
`define PMRC_DC_LVL_HI  2

// ****************************************************************
// Power control fields
// ****************************************************************
`define PMRC_PC_IDLE   0
`define PMRC_PC_PD     1
`define PMRC_PC_TPD    2
`define PMRC_PC_SWRST  3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define PMRC_UCFG_RST    8'h40
`define PMRC_DETCFG_RST  8'h00
`define PMRC_BOOTVEC_RST 8'h00
`define PMRC_RESET_SOURCE_REG_POR  6'h28
`define PMRC_LOW_VEC     16'h0000
`define PMRC_VEC_LOW_BYTE 8'h00
`define PMRC_RST_HOLD_NS 1000
`define PMRC_OSC_WAIT_NS 2000
`define PMRC_CLK_NS      8
`define PMRC_RST_CYC     ((`PMRC_RST_HOLD_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)
`define PMRC_OSC_CYC     ((`PMRC_OSC_WAIT_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)

`endif

// [design/pmrc_pkg.sv]
/*
  Types for the power monitor and reset control block.
  Assumes the constants header sits beside it.
*/
package pmrc_pkg;
  `include "pmrc_consts.svh"

  // Power state of the device
  typedef enum logic [2:0] {
    PMRC_RUN,
    PMRC_IDLE,
    PMRC_PD,
    PMRC_TPD,
    PMRC_WAKE
  } pmrc_pwr_t;
endpackage

// [design/pmrc_top.sv]
/*
  Power monitor and reset control: supply drop detection gating, low
  power modes, reset generation and reset source bookkeeping, reset
  vector choice, reached over an AHB-Lite slave.
  Assumes comparator outputs from analog detectors, event pulses from
  watchdog and UART on sys_clk, and an external power-on reset on resetn.
*/
`timescale 1ns/1ns
`include "pmrc_consts.svh"

// Operation
// - Supply-drop reset always active except total power-down; no software disable.
// - Supply-drop interrupt enable is separate from reset and flash protection.
// - Flash protect detector on outside power-down modes, fixed 2.4 V level.
// - Four levels each: two user-config bits for reset, two detector bits for irq.
// - Drop condition follows supply versus selected level while detection enabled.
// - Power-on flag set at power-up, held until software clears it.
// - Idle keeps peripherals running; any enabled interrupt or reset ends idle.
// - Power-down stops oscillator; exit only by reset or wake-capable interrupt.
// - Power-down keeps detector, watchdog, comparators, timer; RC off unless needed.
// - Total power-down also switches off drop detection and comparators.
// - Shared pin is active-low reset when pin enable is 1, else plain input.
// - Pin always acts as reset during power-up; nothing else overrides enable.
// - Reset from pin, power-on, drop, watchdog, software or UART break.
// - Each source has a readable flag; writing 0 clears it.
// - Power-on reset sets power-on and drop flags, clears all others.
// - Watchdog reset flags as power-on: power-on and drop set, others cleared.
// - Other resets set their own flag and keep uncleared flags.
// - Fetch from 0000H or boot vector high byte with low byte 00H.
// - Boot address after UART break, boot status bit 0 set, or forced programming.
// - Only power-on and watchdog resets return the system timer to defaults.
module pmrc_top
  import pmrc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog detector outputs and shared reset pin, asynchronous: detectors high while supply below level
  input  wire logic [3:0]  drop_below_level,
  input  wire logic [3:0]  irq_below_level,
  input  wire logic        flash_below_level,
  input  wire logic        shared_reset_pin,
  // Events on sys_clk
  input  wire logic        wdt_timeout,
  input  wire logic        uart_break,
  input  wire logic        irq_pending,
  input  wire logic        wake_irq,
  input  wire logic        isp_force,
  input  wire logic        boot_status_byte_b0,
  input  wire logic        rc_is_sysclk,
  input  wire logic        timer_enabled,
  // Outputs
  output logic             sys_reset,
  output logic             timer_reset,
  output logic [15:0]      reset_vector,
  output logic             core_clk_run,
  output logic             periph_run,
  output logic             osc_enable,
  output logic             rc_osc_enable,
  output logic             drop_det_enable,
  output logic             comparator_enable,
  output logic             flash_protect,
  output logic             drop_irq,
  output logic             pin_input
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire  [NSYNC-1:0] async_in = {shared_reset_pin, flash_below_level, irq_below_level, drop_below_level};

  // Two stages; only sync_b is read by logic
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= {NSYNC{1'b1}} ^ {1'b0, {9{1'b1}}};
      sync_b <= {NSYNC{1'b1}} ^ {1'b0, {9{1'b1}}};
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  wire [3:0] drop_lv_s  = sync_b[3:0];
  wire [3:0] irq_lv_s   = sync_b[7:4];
  wire       flash_lv_s = sync_b[8];
  wire       pin_s      = sync_b[9];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [`PMRC_RS_W-1:0] reset_source_reg;
  logic [7:0]  user_config_word;
  logic [7:0]  drop_detect_config;
  logic [7:0]  boot_vec;
  pmrc_pwr_t   pwr;
  logic        in_powerup;
  logic        in_reset;
  logic [15:0] cnt;
  logic        wr_pend;
  logic [7:0]  wr_ofs;

  localparam logic [15:0] RST_CYC = 16'(`PMRC_RST_CYC);
  localparam logic [15:0] OSC_CYC = 16'(`PMRC_OSC_CYC);

  // ****************************************************************
  // Detector selection
  // ****************************************************************
  wire       tpd_now       = (pwr == PMRC_TPD);
  wire       pd_any        = (pwr == PMRC_PD) || tpd_now;
  wire [1:0] drop_rst_sel  = {user_config_word[`PMRC_UC_LVL_HI], user_config_word[`PMRC_UC_LVL_LO]};
  wire [1:0] drop_irq_sel  = {drop_detect_config[`PMRC_DC_LVL_HI], drop_detect_config[`PMRC_DC_LVL_LO]};
  wire       drop_rst_cond = !tpd_now && drop_lv_s[drop_rst_sel];
  wire       drop_irq_cond = !tpd_now && drop_detect_config[`PMRC_DC_IRQ_EN]
                             && irq_lv_s[drop_irq_sel];
  wire       reset_pin_enable           = user_config_word[`PMRC_UC_RPE];
  wire       pin_rst       = !pin_s && (reset_pin_enable || in_powerup);

  // ****************************************************************
  // AHB-Lite decode
  // ****************************************************************
  wire        acc     = hsel && hready && htrans[1];
  wire        wr_acc  = acc && hwrite;
  wire [7:0]  a_ofs   = haddr[7:0];
  wire        wr_rs   = wr_pend && (wr_ofs == `PMRC_OFS_RESET_SOURCE_REG);
  wire        wr_uc   = wr_pend && (wr_ofs == `PMRC_OFS_UCFG);
  wire        wr_dc   = wr_pend && (wr_ofs == `PMRC_OFS_DETCFG);
  wire        wr_pc   = wr_pend && (wr_ofs == `PMRC_OFS_PWRCTL);
  wire        wr_bv   = wr_pend && (wr_ofs == `PMRC_OFS_BOOTVEC);
  wire        sw_rst  = wr_pc && hwdata[`PMRC_PC_SWRST];
  wire [7:0]  status  = {2'h0, in_reset, pd_any, drop_irq_cond, drop_rst_cond, flash_lv_s, pin_s};

  // Read mux; unmapped words read zero
  wire [31:0] rd_mux =
    (a_ofs == `PMRC_OFS_RESET_SOURCE_REG)  ? {26'h0, reset_source_reg} :
    (a_ofs == `PMRC_OFS_UCFG)    ? {24'h0, user_config_word} :
    (a_ofs == `PMRC_OFS_DETCFG)  ? {24'h0, drop_detect_config} :
    (a_ofs == `PMRC_OFS_PWRCTL)  ? {29'h0, tpd_now, pwr == PMRC_PD, pwr == PMRC_IDLE} :
    (a_ofs == `PMRC_OFS_STATUS)  ? {24'h0, status} :
    (a_ofs == `PMRC_OFS_BOOTVEC) ? {24'h0, boot_vec} : 32'h0000_0000;

  // ****************************************************************
  // Reset event classification
  // ****************************************************************
  wire por_like  = wdt_timeout;
  wire other_rst = pin_rst || drop_rst_cond || sw_rst || uart_break;
  wire any_rst   = por_like || other_rst;

  // Flags: hardware set wins over software clear
  wire [`PMRC_RS_W-1:0] set_bits = {1'b0, uart_break, drop_rst_cond, 1'b0, sw_rst, pin_rst};
  wire [`PMRC_RS_W-1:0] kept     = wr_rs ? (reset_source_reg & hwdata[`PMRC_RS_W-1:0]) : reset_source_reg;
  wire [`PMRC_RS_W-1:0] next_rs  = por_like ? `PMRC_RESET_SOURCE_REG_POR : (kept | set_bits);

  // Boot vector choice when a reset starts, and through the power-up hold
  wire use_boot = uart_break || boot_status_byte_b0 || (in_powerup && isp_force);

  // ****************************************************************
  // Bus data phase bookkeeping
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= wr_acc;
      wr_ofs  <= a_ofs;
      if (acc && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************************************
  // Config registers; power-on writes the defaults
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      user_config_word   <= `PMRC_UCFG_RST;
      drop_detect_config <= `PMRC_DETCFG_RST;
      boot_vec           <= `PMRC_BOOTVEC_RST;
    end else begin
      if (wr_uc)
        user_config_word <= hwdata[7:0];
      if (wr_dc)
        drop_detect_config <= hwdata[7:0];
      if (wr_bv)
        boot_vec <= hwdata[7:0];
    end
  end

  // Power-on sets power-on and drop flags only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      reset_source_reg <= `PMRC_RESET_SOURCE_REG_POR;
    else
      reset_source_reg <= next_rs;
  end

  // ****************************************************************
  // Reset sequencer and power state
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_powerup <= 1'b1;
      in_reset   <= 1'b1;
      cnt        <= RST_CYC;
      pwr        <= PMRC_RUN;
    end else if (any_rst) begin
      in_reset <= 1'b1;
      cnt      <= RST_CYC;
      pwr      <= PMRC_RUN;
    end else if (in_reset) begin
      // Hold the core until the stretch runs out
      if (cnt == 16'h0000) begin
        in_reset   <= 1'b0;
        in_powerup <= 1'b0;
      end else begin
        cnt <= cnt - 16'h0001;
      end
    end else begin
      case (pwr)
        PMRC_RUN: begin
          if (wr_pc && hwdata[`PMRC_PC_TPD])
            pwr <= PMRC_TPD;
          else if (wr_pc && hwdata[`PMRC_PC_PD])
            pwr <= PMRC_PD;
          else if (wr_pc && hwdata[`PMRC_PC_IDLE])
            pwr <= PMRC_IDLE;
        end
        PMRC_IDLE: begin
          if (irq_pending)
            pwr <= PMRC_RUN;
        end
        PMRC_PD, PMRC_TPD: begin
          if (wake_irq) begin
            pwr <= PMRC_WAKE;
            cnt <= OSC_CYC;
          end
        end
        PMRC_WAKE: begin
          // Oscillator settles before the core clock returns
          if (cnt == 16'h0000)
            pwr <= PMRC_RUN;
          else
            cnt <= cnt - 16'h0001;
        end
        default: pwr <= PMRC_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  wire next_rc = !pd_any || (rc_is_sysclk && timer_enabled);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sys_reset         <= 1'b1;
      timer_reset       <= 1'b1;
      reset_vector      <= `PMRC_LOW_VEC;
      core_clk_run      <= 1'b0;
      periph_run        <= 1'b1;
      osc_enable        <= 1'b1;
      rc_osc_enable     <= 1'b1;
      drop_det_enable   <= 1'b1;
      comparator_enable <= 1'b1;
      flash_protect     <= 1'b0;
      drop_irq          <= 1'b0;
      pin_input         <= 1'b1;
    end else begin
      sys_reset         <= any_rst || in_reset;
      timer_reset       <= por_like;
      // Power-up hold honours boot status and forced programming; set only, so a late change cannot clear it
      if (any_rst)
        reset_vector    <= use_boot ? {boot_vec, `PMRC_VEC_LOW_BYTE} : `PMRC_LOW_VEC;
      else if (in_powerup && use_boot)
        reset_vector    <= {boot_vec, `PMRC_VEC_LOW_BYTE};
      core_clk_run      <= !in_reset && (pwr == PMRC_RUN);
      periph_run        <= !pd_any;
      osc_enable        <= !pd_any;
      rc_osc_enable     <= next_rc;
      drop_det_enable   <= !tpd_now;
      comparator_enable <= !tpd_now;
      flash_protect     <= !pd_any && flash_lv_s;
      drop_irq          <= drop_irq_cond;
      pin_input         <= (reset_pin_enable || in_powerup) ? 1'b1 : pin_s;
    end
  end

endmodule

// [verif/pmrc_supply_model.sv]
/*
  Supply and external reset circuit on the far side of the block: turns a
  supply level in millivolts into the analog detector outputs and drives the pin.
  Assumes the bench sets vdd_mv and pin_low_req; trip levels are plain defaults.
*/
`timescale 1ns/1ns
module pmrc_supply_model #(
  parameter logic [15:0] RST_MV [4] = '{16'h07D0, 16'h0834, 16'h0898, 16'h08FC},
  parameter logic [15:0] IRQ_MV [4] = '{16'h09C4, 16'h0A28, 16'h0A8C, 16'h0AF0}
) (
  input  wire logic [15:0] vdd_mv,
  input  wire logic        pin_low_req,
  output logic      [3:0]  drop_below_level,
  output logic      [3:0]  irq_below_level,
  output logic             flash_below_level,
  output logic             shared_reset_pin
);
  localparam logic [15:0] FLASH_MV = 16'h0960; // One fixed trip
  // Raw comparators; gating by power state is the block's job, not ours
  // Interrupt trips sit above every reset trip so the warning comes first
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      drop_below_level[n] = vdd_mv < RST_MV[n];
      irq_below_level[n]  = vdd_mv < IRQ_MV[n];
    end
    flash_below_level = vdd_mv < FLASH_MV;
  end
  // Pulled up unless asked low; the bench never holds it through power-on
  assign shared_reset_pin = !pin_low_req;
endmodule

// [verif/pmrc_top_asserts.sv]
/*
  Concurrent checks on the ports of the power monitor and reset control top.
  Assumes sys_clk is the only clock and resetn the asynchronous reset.
*/
`timescale 1ns/1ns
`include "pmrc_consts.svh"
module pmrc_chk (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       hresp,
  input wire logic [3:0] drop_below_level,
  input wire logic       flash_below_level,
  input wire logic       wdt_timeout,
  input wire logic       wake_irq,
  input wire logic       rc_is_sysclk,
  input wire logic       timer_enabled,
  input wire logic       sys_reset,
  input wire logic       timer_reset,
  input wire logic       core_clk_run,
  input wire logic       osc_enable,
  input wire logic       rc_osc_enable,
  input wire logic       drop_det_enable,
  input wire logic       comparator_enable,
  input wire logic       flash_protect
);
  logic [11:0] hi_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Length of the running reset hold; saturates so a stuck reset cannot wrap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= 12'h000;
    end else begin
      hi_cnt <= sys_reset ? hi_cnt + {11'h000, hi_cnt != 12'hFFF} : 12'h000;
    end
  end
  // ********************
  // Properties
  // ********************
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  a_wdt_timer: assert property (wdt_timeout |-> ##[1:4] timer_reset)
    else $error("no timer reset after watchdog");
  a_timer_cause: assert property ($rose(timer_reset) |->
    ($past(wdt_timeout, 1) || $past(wdt_timeout, 2) || $past(wdt_timeout, 3) || $past(wdt_timeout, 4)) ##1 !timer_reset)
    else $error("timer reset without watchdog");
  a_hold_min: assert property ($fell(sys_reset) |-> hi_cnt >= `PMRC_RST_CYC)
    else $error("reset hold too short");
  a_drop_reset: assert property ((&drop_below_level && drop_det_enable) [*5] |-> sys_reset)
    else $error("supply drop gave no reset");
  a_flash_guard: assert property ((flash_below_level && osc_enable) [*5] |-> flash_protect)
    else $error("flash not protected");
  a_osc_cause: assert property ($rose(osc_enable) |-> $past(wake_irq) or (##[0:2] sys_reset))
    else $error("oscillator restarted without cause");
  a_core_wait: assert property ($rose(osc_enable) |-> !core_clk_run [*8])
    else $error("core ran before oscillator settled");
  a_rc_gate: assert property (!osc_enable && !$past(osc_enable) |->
    rc_osc_enable == (rc_is_sysclk && timer_enabled))
    else $error("RC oscillator gating wrong");
  // Detector and comparators go off together, and only while the oscillator is stopped
  a_tpd_pair: assert property (!comparator_enable || !drop_det_enable |->
    !osc_enable && !comparator_enable && !drop_det_enable)
    else $error("comparators and detector disagree");
  c_wdt: cover property (wdt_timeout ##[1:4] timer_reset);
  c_wake: cover property ($rose(osc_enable) ##[8:600] core_clk_run);
  c_tpd: cover property ($fell(drop_det_enable));
endmodule

bind pmrc_top pmrc_chk u_chk (.sys_clk, .resetn, .hresp, .drop_below_level, .flash_below_level, .wdt_timeout,
  .wake_irq, .rc_is_sysclk, .timer_enabled, .sys_reset, .timer_reset, .core_clk_run, .osc_enable,
  .rc_osc_enable, .drop_det_enable, .comparator_enable, .flash_protect);

// [verif/testbench.sv]
/*
  Self-checking bench for the power monitor and reset control block.
  Assumes the supply model on the detector and pin side and an AHB-Lite master here.
*/
`timescale 1ns/1ns
`include "pmrc_consts.svh"
module testbench;
  localparam logic [15:0] RST_MV [4] = '{16'h07D0, 16'h0834, 16'h0898, 16'h08FC};
  localparam logic [15:0] IRQ_MV [4] = '{16'h09C4, 16'h0A28, 16'h0A8C, 16'h0AF0};
  localparam logic [15:0] VDD_OK     = 16'h0CE4;
  localparam logic [7:0]  FLAGS [4]  = '{8'h02, 8'h03, 8'h13, 8'h28};
  logic        sys_clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, wdt_timeout = 1'b0, uart_break = 1'b0;
  logic        irq_pending = 1'b0, wake_irq = 1'b0, boot_status_byte_b0 = 1'b0, pin_low = 1'b0;
  logic        rc_is_sysclk = 1'b0, timer_enabled = 1'b0, isp_force = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] vdd_mv = VDD_OK, reset_vector;
  logic [3:0]  drop_below_level, irq_below_level;
  logic        hreadyout, hresp, flash_below_level, shared_reset_pin, sys_reset, timer_reset, core_clk_run;
  logic        periph_run, osc_enable, rc_osc_enable, drop_det_enable, comparator_enable, flash_protect;
  logic        drop_irq, pin_input;
  int          error_cnt = 0, cmp_count = 0;

  pmrc_top dut (.sys_clk, .resetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .drop_below_level, .irq_below_level, .flash_below_level,
    .shared_reset_pin, .wdt_timeout, .uart_break, .irq_pending, .wake_irq, .isp_force,
    .boot_status_byte_b0, .rc_is_sysclk, .timer_enabled, .sys_reset, .timer_reset, .reset_vector,
    .core_clk_run, .periph_run, .osc_enable, .rc_osc_enable, .drop_det_enable, .comparator_enable,
    .flash_protect, .drop_irq, .pin_input);
  pmrc_supply_model #(.RST_MV(RST_MV), .IRQ_MV(IRQ_MV)) u_supply (.vdd_mv, .pin_low_req(pin_low),
    .drop_below_level, .irq_below_level, .flash_below_level, .shared_reset_pin);

  // 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // ********************
  // Helpers
  // ********************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] vec_exp(input logic boot, input logic [7:0] bv);
    return boot ? {bv, `PMRC_VEC_LOW_BYTE} : `PMRC_LOW_VEC;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One single transfer; waits on hready, never a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] t;
    bus(1'b0, a, 32'h0, t);
    chk(t, exp, what);
  endtask
  // Reset must be up, then released within a bounded wait
  task automatic settle();
    int n;
    n = 0;
    cyc(6);
    chk(sys_reset, 1, "reset raised");
    while (sys_reset !== 1'b0 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk(sys_reset, 0, "reset released");
  endtask
  task automatic fire(input int k);
    if (k == 0) begin
      wr(`PMRC_OFS_PWRCTL, 32'h8);
    end else if (k == 1) begin
      pin_low <= 1'b1;
      cyc(4);
      pin_low <= 1'b0;
    end else if (k == 2) begin
      uart_break <= 1'b1;
      cyc(1);
      uart_break <= 1'b0;
    end else begin
      wdt_timeout <= 1'b1;
      cyc(1);
      wdt_timeout <= 1'b0;
    end
  endtask
  task automatic note(input string s);
    $display("test %s done: %0d checks, %0d wrong", s, cmp_count, error_cnt);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs a few thousand cycles; this leaves ample margin
  initial begin
    cyc(40000);
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    logic [7:0] bv, r;
    logic [1:0] lv;
    int         n;
    r = 8'h34;
    cyc(5);
    resetn <= 1'b1;
    settle();
    rd(`PMRC_OFS_RESET_SOURCE_REG, 32'h28, "power-on flags");
    rd(`PMRC_OFS_UCFG, 32'h40, "user config reset");
    rd(`PMRC_OFS_DETCFG, 32'h0, "detector config reset");
    rd(`PMRC_OFS_STATUS, 32'h1, "status after reset");
    rd(8'h1C, 32'h0, "unmapped read");
    chk(reset_vector, `PMRC_LOW_VEC, "power-on vector");
    wr(`PMRC_OFS_RESET_SOURCE_REG, 32'h0);
    rd(`PMRC_OFS_RESET_SOURCE_REG, 32'h0, "flags cleared");
    r = lfsr(r);
    bv = r;
    note("power-on");
    for (int k = 0; k < 4; k++) begin
      boot_status_byte_b0 <= (k == 0);
      wr(`PMRC_OFS_BOOTVEC, {24'h0, bv});
      fire(k);
      settle();
      rd(`PMRC_OFS_RESET_SOURCE_REG, {24'h0, FLAGS[k]}, "reset flags");
      chk(reset_vector, vec_exp(k == 0 || k == 2, bv), "reset vector");
      if (k == 2) begin
        r = lfsr(r);
        wr(`PMRC_OFS_RESET_SOURCE_REG, {24'h0, r});
        rd(`PMRC_OFS_RESET_SOURCE_REG, {24'h0, r & 8'h13}, "flag write clears");
      end
    end
    boot_status_byte_b0 <= 1'b0;
    note("reset sources");
    for (int l = 0; l < 4; l++) begin
      lv = l[1:0];
      wr(`PMRC_OFS_RESET_SOURCE_REG, 32'h0);
      wr(`PMRC_OFS_UCFG, {25'h0, 1'b1, lv[1], 1'b0, lv[0], 3'h0});
      wr(`PMRC_OFS_DETCFG, {29'h0, lv, 1'b1});
      vdd_mv <= IRQ_MV[l] - 16'h000A;
      cyc(6);
      chk(drop_irq, 1, "drop irq raised");
      wr(`PMRC_OFS_DETCFG, {29'h0, lv, 1'b0});
      cyc(4);
      chk(drop_irq, 0, "drop irq masked");
      vdd_mv <= RST_MV[l] + 16'h000A;
      cyc(6);
      chk(sys_reset, 0, "above reset trip");
      vdd_mv <= RST_MV[l] - 16'h000A;
      cyc(8);
      vdd_mv <= VDD_OK;
      settle();
      rd(`PMRC_OFS_RESET_SOURCE_REG, 32'h08, "drop flag");
    end
    vdd_mv <= 16'h092E;
    cyc(6);
    chk(flash_protect, 1, "flash guard on");
    vdd_mv <= VDD_OK;
    cyc(6);
    chk(flash_protect, 0, "flash guard off");
    note("supply drop");
    wr(`PMRC_OFS_UCFG, 32'h0);
    pin_low <= 1'b1;
    cyc(10);
    chk(sys_reset, 0, "pin as input");
    chk(pin_input, 0, "pin low read");
    pin_low <= 1'b0;
    cyc(4);
    chk(pin_input, 1, "pin high read");
    wr(`PMRC_OFS_UCFG, 32'h40);
    wr(`PMRC_OFS_PWRCTL, 32'h1);
    cyc(6);
    chk({core_clk_run, periph_run, osc_enable}, 3'b011, "idle");
    rd(`PMRC_OFS_PWRCTL, 32'h1, "idle state read");
    irq_pending <= 1'b1;
    cyc(6);
    chk(core_clk_run, 1, "idle exit");
    irq_pending <= 1'b0;
    note("pin and idle");
    for (int m = 0; m < 2; m++) begin
      rc_is_sysclk  <= 1'b1;
      timer_enabled <= (m == 0);
      cyc(4);
      wr(`PMRC_OFS_PWRCTL, m ? 32'h4 : 32'h2);
      cyc(6);
      chk({osc_enable, rc_osc_enable, drop_det_enable, comparator_enable}, m ? 4'h0 : 4'h7, "low power");
      if (m) begin
        vdd_mv <= RST_MV[3] - 16'h000A;
        cyc(8);
        chk(sys_reset, 0, "no drop reset in total");
        vdd_mv <= VDD_OK;
        fire(1);
        settle();
      end else begin
        wake_irq <= 1'b1;
        n = 0;
        while (core_clk_run !== 1'b1 && n < 600) begin
          @(posedge sys_clk);
          n++;
        end
        chk(n >= `PMRC_OSC_CYC && n < 600, 1, "wake settle time");
        wake_irq <= 1'b0;
      end
      chk(osc_enable, 1, "oscillator back");
    end
    note("power-down");
    // Second power-on in mid-run: forced programming picks the boot vector written during the hold
    isp_force <= 1'b1;
    resetn    <= 1'b0;
    cyc(2);
    resetn    <= 1'b1;
    r = lfsr(r);
    wr(`PMRC_OFS_BOOTVEC, {24'h0, r});
    settle();
    chk(reset_vector, vec_exp(1'b1, r), "forced boot vector");
    rd(`PMRC_OFS_RESET_SOURCE_REG, 32'h28, "power-on flags again");
    isp_force <= 1'b0;
    note("mid-run reset");
    wrap_up();
  end
endmodule
